//--- shared/wdog_pkg.sv
// Purpose: Shared constants and types for the operating watchdog.
// Assumes: AHB-Lite register bus with 32-bit data, one word per register.
// Notes:   Printed offsets are register indices; byte address is four times the index.
package wdog_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices and address layout.
    localparam int          IDX_W        = 16;
    localparam int          IDX_LSB      = 2;
    localparam int          ADDR_HI      = IDX_W + IDX_LSB;
    localparam logic [15:0] SVC_IDX      = 16'hffff;
    localparam logic [15:0] CFG_IDX      = 16'hfff0;
    localparam logic [15:0] STAT_IDX     = 16'hfff1;
    localparam logic [15:0] MASK_IDX     = 16'hfff2;
    localparam logic [15:0] COUNT_IDX    = 16'hfff3;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and reset values.
    localparam int          CFG_W        = 2;
    localparam int          CFG_DIS_BIT  = 0;
    localparam int          CFG_RATE_BIT = 1;
    localparam logic [1:0]  CFG_RESET    = 2'h0;
    localparam int          EVT_W        = 3;
    localparam int          EVT_TIMEOUT  = 0;
    localparam int          EVT_REFRESH  = 1;
    localparam int          EVT_MONLOCK  = 2;
    localparam logic [2:0]  EVT_RESET    = 3'h0;
    localparam int          SVC_W        = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Bus encodings.
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
    localparam logic        HRESP_OKAY   = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Timing counts, in crystal reference ticks and core cycles.
    localparam int          CNT_W_DEF    = 20;
    localparam int          TO_LONG_DEF  = 65536;
    localparam int          TO_SHORT_DEF = 8192;
    localparam int          XDIV_DEF     = 2;

    typedef enum logic [1:0] {
        MON_NONE,
        MON_TST,
        MON_BLANK
    } mon_state_t;

endpackage : wdog_pkg

//--- shared/wdog_cnt_if.sv
// Purpose: Carries control and status between register side and counter.
// Assumes: One clock domain.
// Notes:   Refresh is a one-cycle pulse, timeout a one-cycle pulse.
`timescale 1ns/1ps
interface wdog_cnt_if #(parameter int CNT_W = 20);
    logic             refresh;
    logic             enable;
    logic             rate_sel;
    logic             stop;
    logic             tick;
    logic             timeout;
    logic [CNT_W-1:0] count;

    modport ctl (output refresh, enable, rate_sel, stop,
                 input  tick, timeout, count);
    modport cnt (input  refresh, enable, rate_sel, stop,
                 output tick, timeout, count);
endinterface : wdog_cnt_if

//--- rtl/wdog_counter.sv
// Purpose: Crystal reference prescaler and watchdog timeout counter.
// Assumes: Inputs synchronous to the core clock.
// Notes:   The prescaler stands in for the system integration counter.
`timescale 1ns/1ps
module wdog_counter #(
    parameter int CNT_W    = wdog_pkg::CNT_W_DEF,
    parameter int TO_LONG  = wdog_pkg::TO_LONG_DEF,
    parameter int TO_SHORT = wdog_pkg::TO_SHORT_DEF,
    parameter int XDIV     = wdog_pkg::XDIV_DEF
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    wdog_cnt_if.cnt    cif
);

    localparam logic [CNT_W-1:0] TERM_LONG  = CNT_W'(TO_LONG - 1);
    localparam logic [CNT_W-1:0] TERM_SHORT = CNT_W'(TO_SHORT - 1);
    localparam logic [15:0]      PRE_LAST   = 16'(XDIV - 1);

    logic [15:0]      pre_ff;
    logic             tick_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic             to_ff;
    logic [CNT_W-1:0] term;

    assign term        = cif.rate_sel ? TERM_SHORT : TERM_LONG;
    assign cif.tick    = tick_ff;
    assign cif.count   = cnt_ff;
    assign cif.timeout = to_ff;

    ////////////////////////////////////////////////////////////////////////////
    // prescaler cleared in stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_ff  <= 16'h0000;
            tick_ff <= 1'b0;
        end else if (cif.stop) begin
            pre_ff  <= 16'h0000;
            tick_ff <= 1'b0;
        end else if (pre_ff == PRE_LAST) begin
            pre_ff  <= 16'h0000;
            tick_ff <= 1'b1;
        end else begin
            pre_ff  <= pre_ff + 16'h0001;
            tick_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // count, clear and timeout
    // A refresh in the same cycle as the terminal tick wins, so no reset follows it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            to_ff  <= 1'b0;
        end else if (!cif.enable || cif.refresh) begin
            cnt_ff <= '0;
            to_ff  <= 1'b0;
        end else if (tick_ff && !cif.stop) begin
            to_ff  <= (cnt_ff == term);
            cnt_ff <= (cnt_ff == term) ? '0 : cnt_ff + 1'b1;
        end else begin
            to_ff  <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_stop_freeze:   assert property (cif.stop && !cif.refresh |=>
        $stable(cnt_ff) || cnt_ff == '0) else $error("counter moved in stop");
    a_refresh_clear: assert property (cif.refresh |=> cnt_ff == '0 && !to_ff)
        else $error("refresh did not clear counter");
    a_term_wrap:     assert property (to_ff |-> cnt_ff == '0)
        else $error("timeout without counter wrap");

endmodule : wdog_counter

//--- rtl/wdog_top.sv
// Purpose: Operating watchdog with AHB-Lite register access.
// Assumes: Side pins synchronous to CORE_CLK; RSTN is the power-on reset.
// Notes:   The attention output is not a processor interrupt; it flags events.
`timescale 1ns/1ps
module wdog_top #(
    parameter int CNT_W    = wdog_pkg::CNT_W_DEF,
    parameter int TO_LONG  = wdog_pkg::TO_LONG_DEF,
    parameter int TO_SHORT = wdog_pkg::TO_SHORT_DEF,
    parameter int XDIV     = wdog_pkg::XDIV_DEF
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic [7:0]  RESET_VECTOR_LO,
    input  wire logic        MON_ENTRY,
    input  wire logic        TST_ON_IRQ,
    input  wire logic        TST_ON_RST,
    input  wire logic        VECTORS_BLANK,
    input  wire logic        STOP_MODE,
    output logic             WDOG_RESET_REQ,
    output logic             WDOG_RATE_SEL,
    output logic             EVT_IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release.

    // Release is synchronised so every flop leaves reset on the same edge.
    logic rst_meta_ff;
    logic rst_n;

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_ff <= 1'b0;
            rst_n       <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n       <= rst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    function automatic logic reg_hit(input logic [31:0] addr, input logic [15:0] idx);
        reg_hit = (addr[31:wdog_pkg::ADDR_HI] == '0)
               && (addr[wdog_pkg::ADDR_HI-1:wdog_pkg::IDX_LSB] == idx)
               && (addr[1:0] == 2'h0);
    endfunction : reg_hit

    wdog_cnt_if #(.CNT_W(CNT_W)) cif ();

    logic                        acc;
    logic                        rd_acc;
    logic                        wr_svc_ff;
    logic                        wr_cfg_ff;
    logic                        wr_mask_ff;
    logic [wdog_pkg::CFG_W-1:0]  cfg_ff;
    logic [wdog_pkg::EVT_W-1:0]  stat_ff;
    logic [wdog_pkg::EVT_W-1:0]  mask_ff;
    logic [wdog_pkg::EVT_W-1:0]  evt_set;
    logic [31:0]                 rd_mux;
    logic                        stat_rd_clr;
    wdog_pkg::mon_state_t        mon_ff;
    wdog_pkg::mon_state_t        nxt_mon;
    logic                        lock_entry;

    // SEQ is taken as well; it costs nothing and a burst master is then not ignored.
    assign acc    = HSEL && HREADY && (HTRANS == wdog_pkg::HTRANS_NSEQ || HTRANS == 2'h3);
    assign rd_acc = acc && !HWRITE;

    ////////////////////////////////////////////////////////////////////////////
    // Bus write capture; data follows in the next cycle.

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_svc_ff  <= 1'b0;
            wr_cfg_ff  <= 1'b0;
            wr_mask_ff <= 1'b0;
        end else begin
            wr_svc_ff  <= acc && HWRITE && reg_hit(HADDR, wdog_pkg::SVC_IDX);
            wr_cfg_ff  <= acc && HWRITE && reg_hit(HADDR, wdog_pkg::CFG_IDX);
            wr_mask_ff <= acc && HWRITE && reg_hit(HADDR, wdog_pkg::MASK_IDX);
        end
    end

    assign cif.refresh = wr_svc_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and mask registers.

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff <= wdog_pkg::CFG_RESET;
        end else if (wr_cfg_ff) begin
            cfg_ff <= HWDATA[wdog_pkg::CFG_W-1:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= wdog_pkg::EVT_RESET;
        end else if (wr_mask_ff) begin
            mask_ff <= HWDATA[wdog_pkg::EVT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Monitor mode tracking.

    // Entry acts only from the idle state, so a held entry level cannot re-arm a lock.
    always_comb begin
        nxt_mon = mon_ff;
        case (mon_ff)
            wdog_pkg::MON_NONE: begin
                if (MON_ENTRY && TST_ON_IRQ) begin
                    nxt_mon = wdog_pkg::MON_TST;
                end else if (MON_ENTRY && VECTORS_BLANK) begin
                    nxt_mon = wdog_pkg::MON_BLANK;
                end
            end
            wdog_pkg::MON_TST: begin
                if (!TST_ON_IRQ && !TST_ON_RST) begin
                    nxt_mon = wdog_pkg::MON_NONE;
                end
            end
            wdog_pkg::MON_BLANK: begin
                nxt_mon = wdog_pkg::MON_BLANK;
            end
            default: begin
                nxt_mon = wdog_pkg::MON_NONE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            mon_ff <= wdog_pkg::MON_NONE;
        end else begin
            mon_ff <= nxt_mon;
        end
    end

    assign lock_entry = (mon_ff == wdog_pkg::MON_NONE) && (nxt_mon != wdog_pkg::MON_NONE);

    ////////////////////////////////////////////////////////////////////////////
    // Counter control.
    // Wait mode is deliberately absent here: the counter keeps running through it.

    assign cif.enable   = !cfg_ff[wdog_pkg::CFG_DIS_BIT]
                       && (mon_ff == wdog_pkg::MON_NONE);
    assign cif.rate_sel = cfg_ff[wdog_pkg::CFG_RATE_BIT];
    assign cif.stop     = STOP_MODE;

    wdog_counter #(
        .CNT_W    (CNT_W),
        .TO_LONG  (TO_LONG),
        .TO_SHORT (TO_SHORT),
        .XDIV     (XDIV)
    ) u_counter (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .cif   (cif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Reset request and rate select outputs.

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            WDOG_RESET_REQ <= 1'b0;
            WDOG_RATE_SEL  <= 1'b0;
        end else begin
            WDOG_RESET_REQ <= cif.timeout;
            WDOG_RATE_SEL  <= cif.rate_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event status; a read clears it, but a same-cycle event survives.
    // These bits feed the attention line and read back at STAT_IDX; neither is a processor interrupt.

    assign evt_set     = {lock_entry, cif.refresh, cif.timeout};
    assign stat_rd_clr = rd_acc && reg_hit(HADDR, wdog_pkg::STAT_IDX);

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            stat_ff <= wdog_pkg::EVT_RESET;
        end else begin
            stat_ff <= (stat_rd_clr ? wdog_pkg::EVT_RESET : stat_ff) | evt_set;
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            EVT_IRQ <= 1'b0;
        end else begin
            EVT_IRQ <= |(stat_ff & mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, registered at the address phase.
    // The count view is read-only; reading it never refreshes the watchdog.

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (reg_hit(HADDR, wdog_pkg::SVC_IDX)) begin
            rd_mux = {24'h00_0000, RESET_VECTOR_LO};
        end else if (reg_hit(HADDR, wdog_pkg::CFG_IDX)) begin
            rd_mux = {30'h0000_0000, cfg_ff};
        end else if (reg_hit(HADDR, wdog_pkg::STAT_IDX)) begin
            rd_mux = {29'h0000_0000, stat_ff};
        end else if (reg_hit(HADDR, wdog_pkg::MASK_IDX)) begin
            rd_mux = {29'h0000_0000, mask_ff};
        end else if (reg_hit(HADDR, wdog_pkg::COUNT_IDX)) begin
            rd_mux = 32'(cif.count);
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            HRDATA <= 32'h0000_0000;
        end else if (rd_acc) begin
            HRDATA <= rd_mux;
        end
    end

    // Zero wait states: every transfer completes in its data phase with OKAY.
    // A wait state would only delay a refresh, and no register needs one.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            HREADYOUT <= 1'b1;
            HRESP     <= wdog_pkg::HRESP_OKAY;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= wdog_pkg::HRESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!rst_n);

    a_svc_write_refresh: assert property (
        acc && HWRITE && reg_hit(HADDR, wdog_pkg::SVC_IDX) |=> cif.refresh ##1 cif.count == '0)
        else $error("service write did not restart the count");
    a_svc_read_vector: assert property (
        rd_acc && reg_hit(HADDR, wdog_pkg::SVC_IDX) |=>
        HRDATA == {24'h00_0000, $past(RESET_VECTOR_LO)} && !cif.refresh)
        else $error("service read returned wrong data or refreshed");
    a_timeout_reset: assert property (
        cif.timeout |=> WDOG_RESET_REQ && $past(cif.enable, 2))
        else $error("timeout without a reset request");
    a_req_one_clock: assert property (
        WDOG_RESET_REQ |=> !WDOG_RESET_REQ)
        else $error("reset request longer than one clock");
    a_tst_hold_off: assert property (
        mon_ff == wdog_pkg::MON_TST && (TST_ON_IRQ || TST_ON_RST) |=>
        mon_ff == wdog_pkg::MON_TST && !cif.enable)
        else $error("watchdog enabled under test voltage");
    a_blank_locked: assert property (
        mon_ff == wdog_pkg::MON_BLANK |=> mon_ff == wdog_pkg::MON_BLANK ##1 !cif.enable)
        else $error("blank vector lock released");
    a_disable_bit: assert property (
        cfg_ff[wdog_pkg::CFG_DIS_BIT] |-> !cif.enable ##1 cif.count == '0 || !$past(cfg_ff[0]))
        else $error("disable bit did not stop the watchdog");
    a_rate_route: assert property (
        wr_cfg_ff |=> cif.rate_sel == $past(HWDATA[1]) ##1 WDOG_RATE_SEL == $past(cif.rate_sel))
        else $error("rate select not routed");
    a_stat_set_wins: assert property (
        cif.timeout && stat_rd_clr |=> stat_ff[wdog_pkg::EVT_TIMEOUT])
        else $error("timeout event lost on read clear");

    // Config, refresh, request, entry, counting, status and attention checks that the bench reaches only indirectly.
    a_cfg_write_lands: assert property (
        wr_cfg_ff |=> cfg_ff == $past(HWDATA[wdog_pkg::CFG_W-1:0]))
        else $error("config write did not land");
    a_refresh_source: assert property (
        cif.refresh |-> $past(acc && HWRITE && reg_hit(HADDR, wdog_pkg::SVC_IDX)))
        else $error("refresh without a service write");
    a_req_from_timeout: assert property (
        WDOG_RESET_REQ |-> $past(cif.timeout))
        else $error("reset request without a timeout");
    a_tst_entry: assert property (
        mon_ff == wdog_pkg::MON_NONE && MON_ENTRY && TST_ON_IRQ |=>
        mon_ff == wdog_pkg::MON_TST && !cif.enable)
        else $error("test voltage entry did not disable");
    a_blank_entry: assert property (
        mon_ff == wdog_pkg::MON_NONE && MON_ENTRY && VECTORS_BLANK && !TST_ON_IRQ |=>
        mon_ff == wdog_pkg::MON_BLANK && !cif.enable)
        else $error("blank vector entry did not lock");
    a_wait_counts: assert property (
        cif.enable && !cif.stop && !cif.refresh && cif.tick |=> cif.count != $past(cif.count))
        else $error("enabled counter did not advance");
    a_stop_no_tick: assert property (
        cif.stop |=> !cif.tick)
        else $error("reference tick ran in stop");
    a_stat_sticky: assert property (
        !stat_rd_clr |=> ($past(stat_ff) & ~stat_ff) == '0)
        else $error("status bit lost without a read");
    a_stat_read_clear: assert property (
        stat_rd_clr && evt_set == '0 |=> stat_ff == '0)
        else $error("status read did not clear");
    a_irq_follows: assert property (
        1'b1 |=> EVT_IRQ == $past(|(stat_ff & mask_ff)))
        else $error("attention line out of step with status");

    c_refresh:   cover property (wr_svc_ff);
    c_timeout:   cover property (cif.timeout ##1 WDOG_RESET_REQ);
    c_blank:     cover property (mon_ff == wdog_pkg::MON_BLANK);
    c_stop_hold: cover property ((STOP_MODE && cif.enable) [*4]);

endmodule : wdog_top

//--- test/testbench.sv
// Purpose: Self-checking bench for the operating watchdog top.
// Assumes: Zero-wait AHB-Lite slave, shortened counts TO_L, TO_S, XD.
// Notes:   Random data from a fixed xorshift seed; timing checked in windows.
`timescale 1ns/1ps
module testbench;
    localparam int          TO_L = 16;
    localparam int          TO_S = 4;
    localparam int          XD   = 1;
    localparam logic [15:0] UNMAPPED_IDX = 16'h1234;

    logic        CORE_CLK, RSTN, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
    logic [31:0] HADDR, HWDATA, HRDATA;
    logic [1:0]  HTRANS;
    logic [2:0]  HSIZE;
    logic [7:0]  RESET_VECTOR_LO;
    logic        MON_ENTRY, TST_ON_IRQ, TST_ON_RST, VECTORS_BLANK, STOP_MODE;
    logic        WDOG_RESET_REQ, WDOG_RATE_SEL, EVT_IRQ;
    int          num_errors, samples_checked, req_cnt, n, c0;
    logic        req_prev;
    logic [31:0] seed, d, e;

    assign HREADY = HREADYOUT;

    wdog_top #(.CNT_W(20), .TO_LONG(TO_L), .TO_SHORT(TO_S), .XDIV(XD)) dut (
        .CORE_CLK(CORE_CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .RESET_VECTOR_LO(RESET_VECTOR_LO), .MON_ENTRY(MON_ENTRY),
        .TST_ON_IRQ(TST_ON_IRQ), .TST_ON_RST(TST_ON_RST),
        .VECTORS_BLANK(VECTORS_BLANK), .STOP_MODE(STOP_MODE),
        .WDOG_RESET_REQ(WDOG_RESET_REQ), .WDOG_RATE_SEL(WDOG_RATE_SEL),
        .EVT_IRQ(EVT_IRQ));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        CORE_CLK = 1'b0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end

    // A reset request must be a single-cycle pulse, so two highs in a row are flagged.
    always @(posedge CORE_CLK) begin
        if (WDOG_RESET_REQ === 1'b1) begin
            req_cnt++;
            if (req_prev) begin
                $display("unexpected at %0t: reset request longer than one cycle", $time);
                num_errors++;
            end
        end
        req_prev = (WDOG_RESET_REQ === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [31:0] exp_svc(input logic [7:0] vec);
        return {24'h0, vec};
    endfunction : exp_svc

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
            num_errors++;
        end
    endtask : check

    task automatic test_done();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////
    // The master holds each phase until hready is seen high at a rising edge.
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge CORE_CLK);
        HSEL   <= 1'b1;
        HTRANS <= wdog_pkg::HTRANS_NSEQ;
        HWRITE <= wr;
        HADDR  <= {14'h0, idx, 2'b00};
        HSIZE  <= 3'h2;
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        HSEL   <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
        check({31'h0, HRESP}, {31'h0, wdog_pkg::HRESP_OKAY}, "response");
    endtask : bus

    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        logic [31:0] x;
        bus(1'b1, idx, wd, x);
    endtask : wr

    task automatic idle(input int k);
        repeat (k) @(posedge CORE_CLK);
    endtask : idle

    task automatic do_reset();
        RSTN <= 1'b0;
        idle(2);
        RSTN <= 1'b1;
        idle(3);
    endtask : do_reset

    // Disable first so a pending count cannot leak into the measured period.
    task automatic measure(input logic [1:0] cfg, output int cyc);
        wr(wdog_pkg::CFG_IDX, 32'h1);
        wr(wdog_pkg::CFG_IDX, {30'h0, cfg});
        wr(wdog_pkg::SVC_IDX, rnd());
        cyc = 0;
        while (WDOG_RESET_REQ !== 1'b1 && cyc < 300) begin
            @(posedge CORE_CLK);
            cyc++;
        end
    endtask : measure

    task automatic quiet(input int k, input logic expect_req, input string msg);
        c0 = req_cnt;
        idle(k);
        check({31'h0, req_cnt > c0}, {31'h0, expect_req}, msg);
    endtask : quiet

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(100 * 20000);
        num_errors++;
        test_done();
    end

    initial begin
        num_errors = 0; samples_checked = 0; req_cnt = 0; req_prev = 1'b0; seed = 32'd90;
        RSTN = 1'b0; HSEL = 1'b0; HADDR = 32'h0; HTRANS = 2'h0; HWRITE = 1'b0;
        HSIZE = 3'h2; HWDATA = 32'h0; RESET_VECTOR_LO = 8'h5a; MON_ENTRY = 1'b0;
        TST_ON_IRQ = 1'b0; TST_ON_RST = 1'b0; VECTORS_BLANK = 1'b0; STOP_MODE = 1'b0;
        do_reset();
        bus(1'b0, wdog_pkg::CFG_IDX, 32'h0, d);
        check(d, {30'h0, wdog_pkg::CFG_RESET}, "config reset");
        bus(1'b0, wdog_pkg::MASK_IDX, 32'h0, d);
        check(d, 32'h0, "mask reset");
        check({31'h0, WDOG_RATE_SEL}, 32'h0, "rate reset");
        // Unmapped place reads zero and ignores writes.
        wr(UNMAPPED_IDX, rnd());
        bus(1'b0, UNMAPPED_IDX, 32'h0, d);
        check(d, 32'h0, "unmapped read");
        // Random vector bytes read back through the service location.
        for (int i = 0; i < 6; i++) begin
            RESET_VECTOR_LO <= 8'(rnd());
            idle(1);
            bus(1'b0, wdog_pkg::SVC_IDX, 32'h0, d);
            check(d, exp_svc(RESET_VECTOR_LO), "service read");
        end
        // Config readback and rate output for every setting.
        for (int i = 0; i < 4; i++) begin
            wr(wdog_pkg::CFG_IDX, {30'(rnd() >> 2), i[1:0]});
            bus(1'b0, wdog_pkg::CFG_IDX, 32'h0, d);
            check(d, {30'h0, i[1:0]}, "config readback");
            check({31'h0, WDOG_RATE_SEL}, {31'h0, i[1]}, "rate output");
        end
        // Long and short periods from a fresh refresh.
        measure(2'h0, n);
        check({31'h0, n >= TO_L * XD && n <= TO_L * XD + 6}, 32'h1, "long period");
        measure(2'h2, n);
        check({31'h0, n >= TO_S * XD && n <= TO_S * XD + 6}, 32'h1, "short period");
        wr(wdog_pkg::CFG_IDX, 32'h0);
        // Steady refresh with random data keeps the reset away at the long period; no pulse may land.
        idle(2);
        c0 = req_cnt;
        for (int i = 0; i < 12; i++) wr(wdog_pkg::SVC_IDX, rnd());
        check(req_cnt - c0, 32'h0, "refresh holds off");
        // Reads of the service place do not refresh.
        c0 = req_cnt;
        for (int i = 0; i < 12; i++) bus(1'b0, wdog_pkg::SVC_IDX, 32'h0, d);
        check({31'h0, req_cnt > c0}, 32'h1, "read no refresh");
        // Disabled watchdog holds its count at zero.
        wr(wdog_pkg::CFG_IDX, 32'h1);
        quiet(60, 1'b0, "disabled");
        bus(1'b0, wdog_pkg::COUNT_IDX, 32'h0, d);
        check(d, 32'h0, "disabled count");
        // Stop freezes a nonzero count; leaving stop resumes counting.
        wr(wdog_pkg::CFG_IDX, 32'h0);
        wr(wdog_pkg::SVC_IDX, rnd());
        idle(5);
        STOP_MODE <= 1'b1;
        bus(1'b0, wdog_pkg::COUNT_IDX, 32'h0, d);
        quiet(60, 1'b0, "stopped");
        bus(1'b0, wdog_pkg::COUNT_IDX, 32'h0, e);
        check(e, d, "frozen count");
        STOP_MODE <= 1'b0;
        quiet(40, 1'b1, "after stop");
        // Event line: timeout never interrupts unless unmasked.
        check({31'h0, EVT_IRQ}, 32'h0, "masked timeout");
        wr(wdog_pkg::MASK_IDX, 32'h1);
        idle(TO_L * XD + 6);
        check({31'h0, EVT_IRQ}, 32'h1, "unmasked timeout");
        wr(wdog_pkg::CFG_IDX, 32'h1);
        bus(1'b0, wdog_pkg::STAT_IDX, 32'h0, d);
        check(d & 32'h1, 32'h1, "timeout status");
        idle(3);
        check({31'h0, EVT_IRQ}, 32'h0, "status cleared");
        bus(1'b0, wdog_pkg::STAT_IDX, 32'h0, d);
        check(d, 32'h0, "read clears");
        wr(wdog_pkg::MASK_IDX, 32'h2);
        wr(wdog_pkg::SVC_IDX, rnd());
        idle(3);
        check({31'h0, EVT_IRQ}, 32'h1, "refresh event");
        bus(1'b0, wdog_pkg::STAT_IDX, 32'h0, d);
        check(d & 32'h2, 32'h2, "refresh status");
        wr(wdog_pkg::MASK_IDX, 32'h0);
        // Monitor entry under test voltage.
        wr(wdog_pkg::CFG_IDX, 32'h0);
        TST_ON_IRQ <= 1'b1;
        MON_ENTRY  <= 1'b1;
        idle(1);
        MON_ENTRY  <= 1'b0;
        quiet(60, 1'b0, "voltage on irq");
        bus(1'b0, wdog_pkg::STAT_IDX, 32'h0, d);
        check(d & 32'h4, 32'h4, "monitor status");
        TST_ON_RST <= 1'b1;
        TST_ON_IRQ <= 1'b0;
        quiet(60, 1'b0, "voltage on reset");
        TST_ON_RST <= 1'b0;
        quiet(60, 1'b1, "voltage gone");
        // Monitor entry from blank vectors lasts until power-on reset.
        VECTORS_BLANK <= 1'b1;
        MON_ENTRY     <= 1'b1;
        idle(1);
        MON_ENTRY     <= 1'b0;
        VECTORS_BLANK <= 1'b0;
        wr(wdog_pkg::SVC_IDX, rnd());
        quiet(80, 1'b0, "blank lock");
        do_reset();
        bus(1'b0, wdog_pkg::COUNT_IDX, 32'h0, d);
        check({31'h0, d < 32'd8}, 32'h1, "count after reset");
        quiet(60, 1'b1, "lock released");
        test_done();
    end
endmodule : testbench
